/* File: design/sim_pkg.sv */
// Package of constants and carrier types for the supply integrity monitor.
//----------------------------------------------------------------------------
// Summary of operation
// R01: Hold chip reset while the low-supply comparator reports low supply.
// R02: Analog comparator gives hysteresis; digital side follows its output.
// R03: Threshold level comes from a static option input, not software.
// R04: Drive the reset pin low while low-supply reset is active.
// R05: No supply reset at all when option disables the detector.
// R06: Low-supply reset wins over watchdog and clears the watchdog cause.
// R07: Warning status is real-time comparator level, read-only.
// R08: Warning detection and interrupt work only with detector enabled.
// R09: Warning threshold follows the selected low-supply threshold.
// R10: Raise a warning request on both falling and rising crossings.
// R11: Forward warning interrupt only when enabled and CPU mask clear.
// R12: Wait mode changes nothing; warning interrupt wakes from wait.
// R13: In halt the control and status contents are frozen; the event status register still records crossings.
// R14: In halt the detector runs but cannot wake the device.
// R15: Illegal opcode or prefix from the CPU also resets the chip.
// R16: Low-supply reset sets a cause flag, cleared only by writing zero.
// R17: Pending warning interrupt clears when the CPU enters its routine.
// R18: Both comparator outputs pass a two-stage synchroniser first.
//----------------------------------------------------------------------------
package sim_pkg;
   localparam logic [3:0] SIM_ADDR_CSR = 4'h0;
   localparam logic [3:0] SIM_ADDR_IRQ_STATUS = 4'h1;
   localparam logic [3:0] SIM_ADDR_IRQ_MASK = 4'h2;
   localparam int SIM_BIT_IRQ_ENABLE = 0;
   localparam int SIM_BIT_WARN_STATUS = 1;
   localparam int SIM_BIT_RESET_CAUSE = 2;
   localparam int SIM_BIT_WDG_CAUSE = 3;
   localparam int SIM_EV_FALL = 0;
   localparam int SIM_EV_RISE = 1;
   localparam logic [1:0] SIM_IRQ_MASK_RESET = 2'h3;
   typedef enum logic [1:0] {
      SIM_LVL_LOW = 2'b00,
      SIM_LVL_MED = 2'b01,
      SIM_LVL_HIGH = 2'b10
   } sim_level_e;
   typedef struct packed {
      logic enable;
      sim_level_e level;
   } sim_option_s;
   typedef struct packed {
      logic wait_mode;
      logic halt_mode;
      logic irq_mask;
      logic irq_ack;
      logic illegal_op;
      logic wdg_reset;
   } sim_cpu_s;
endpackage

/* File: design/sim_monitor.sv */
// Supply integrity monitor: reset generation, warning status and interrupt.
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
module sim_monitor
   import sim_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic low_supply_cmp,
   input wire logic warn_cmp,
   input wire sim_option_s option,
   input wire sim_cpu_s cpu,
   output logic [1:0] cmp_level_sel,
   output logic chip_reset,
   output logic reset_pin_o,
   output logic reset_pin_oe,
   output logic warn_irq,
   output logic wake_req,
   output logic irq,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   //-------------------------------------------------------------------------
   // Synchronisers
   //-------------------------------------------------------------------------
   logic lv_meta, lv_sync, wv_meta, wv_sync, wv_prev;
   always_ff @(posedge clk) begin // see R18
      lv_meta <= low_supply_cmp;
      lv_sync <= lv_meta;
      wv_meta <= warn_cmp;
      wv_sync <= wv_meta;
   end

   // Comparator thresholds are fixed by the option, so hysteresis stays
   // analog; the shared selector keeps both detectors on one level.
   assign cmp_level_sel = option.level; // see R03 // see R09 // see R02

   //-------------------------------------------------------------------------
   // Reset generation
   //-------------------------------------------------------------------------
   logic low_reset;
   assign low_reset = option.enable & lv_sync; // see R01 // see R05
   assign chip_reset = low_reset | cpu.illegal_op; // see R15
   assign reset_pin_o = 1'b0;
   assign reset_pin_oe = low_reset; // see R04

   //-------------------------------------------------------------------------
   // Control and status state
   //-------------------------------------------------------------------------
   logic irq_enable, warn_status, reset_cause, wdg_cause, pending;
   logic [1:0] ev_status, ev_mask, ev_set;
   logic warn_live, bus_wr, bus_rd, hit_csr, hit_st, hit_mk;
   assign warn_live = option.enable & wv_sync; // see R08
   assign bus_wr = avs_write & ~cpu.halt_mode;
   assign bus_rd = avs_read;
   function automatic logic sim_hit(input logic [3:0] a,
                                    input logic [3:0] r);
      return a == r;
   endfunction
   assign hit_csr = sim_hit(avs_address, SIM_ADDR_CSR);
   assign hit_st = sim_hit(avs_address, SIM_ADDR_IRQ_STATUS);
   assign hit_mk = sim_hit(avs_address, SIM_ADDR_IRQ_MASK);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wv_prev <= 1'b0;
      end else begin
         wv_prev <= warn_live;
      end
   end
   assign ev_set[SIM_EV_FALL] = warn_live & ~wv_prev; // see R10
   assign ev_set[SIM_EV_RISE] = ~warn_live & wv_prev; // see R10

   // Status freezes in halt; the comparator itself keeps running.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         warn_status <= 1'b0;
      end else if (!cpu.halt_mode) begin // see R13
         warn_status <= warn_live; // see R07
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq_enable <= 1'b0;
      end else if (bus_wr && hit_csr) begin
         irq_enable <= avs_writedata[SIM_BIT_IRQ_ENABLE];
      end
   end

   // The cause flags must outlive the resets they record, so they are not
   // cleared by rst_b; only the low-supply event itself initialises them.
   always_ff @(posedge clk) begin
      if (low_reset) begin
         reset_cause <= 1'b1; // see R16
         wdg_cause <= 1'b0; // see R06
      end else begin
         if (cpu.wdg_reset) begin
            wdg_cause <= 1'b1;
         end else if (bus_wr && hit_csr &&
                      !avs_writedata[SIM_BIT_WDG_CAUSE]) begin
            wdg_cause <= 1'b0;
         end
         if (bus_wr && hit_csr && !avs_writedata[SIM_BIT_RESET_CAUSE]) begin
            reset_cause <= 1'b0; // see R16
         end
      end
   end

   // Pending request: set beats the acknowledge from interrupt entry.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pending <= 1'b0;
      end else if (!cpu.halt_mode && irq_enable && |ev_set) begin // see R10
         pending <= 1'b1;
      end else if (cpu.irq_ack) begin
         pending <= 1'b0; // see R17
      end
   end
   assign warn_irq = pending & ~cpu.irq_mask; // see R11
   // see R12 // see R14
   assign wake_req = warn_irq & cpu.wait_mode & ~cpu.halt_mode;

   //-------------------------------------------------------------------------
   // Sticky event status and mask
   //-------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ev_status <= 2'h0;
      end else begin
         ev_status <= (ev_status &
                       ~((bus_wr && hit_st) ? avs_writedata[1:0] : 2'h0)) |
                      ev_set;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ev_mask <= SIM_IRQ_MASK_RESET;
      end else if (bus_wr && hit_mk) begin
         ev_mask <= avs_writedata[1:0];
      end
   end
   assign irq = |(ev_status & ~ev_mask);

   //-------------------------------------------------------------------------
   // Avalon slave: zero wait states, unmapped reads return zero
   //-------------------------------------------------------------------------
   assign avs_waitrequest = 1'b0;
   always_comb begin
      avs_readdata = 32'h0;
      if (bus_rd && hit_csr) begin
         avs_readdata[SIM_BIT_IRQ_ENABLE] = irq_enable;
         avs_readdata[SIM_BIT_WARN_STATUS] = warn_status;
         avs_readdata[SIM_BIT_RESET_CAUSE] = reset_cause;
         avs_readdata[SIM_BIT_WDG_CAUSE] = wdg_cause;
      end else if (bus_rd && hit_st) begin
         avs_readdata[1:0] = ev_status;
      end else if (bus_rd && hit_mk) begin
         avs_readdata[1:0] = ev_mask;
      end
   end

   //-------------------------------------------------------------------------
   // Checks
   //-------------------------------------------------------------------------
   chk_reset_follows: assert property (@(posedge clk) // see R01
      (option.enable && lv_sync) |-> chip_reset)
      else $error("reset missing during low supply");
   chk_reset_disabled: assert property (@(posedge clk) // see R05
      (!option.enable && !cpu.illegal_op) |-> !chip_reset)
      else $error("reset while detector disabled");
   chk_pin_drive: assert property (@(posedge clk) // see R04
      reset_pin_oe == low_reset)
      else $error("reset pin drive mismatch");
   chk_wdg_clear: assert property (@(posedge clk) // see R06
      low_reset |=> (!wdg_cause && reset_cause))
      else $error("watchdog cause not cleared");
   chk_warn_sync: assert property (@(posedge clk) // see R18
      (rst_b && option.enable && !cpu.halt_mode)[*3]
      |-> warn_status == $past(wv_meta, 2))
      else $error("status not two-stage synchronised");
   chk_halt_freeze: assert property (@(posedge clk) // see R13
      disable iff (!rst_b) cpu.halt_mode |=> $stable(warn_status))
      else $error("status changed in halt");
   chk_edge_pend: assert property (@(posedge clk) // see R10
      disable iff (!rst_b)
      (|ev_set && irq_enable && !cpu.halt_mode) |=> pending)
      else $error("crossing did not pend");
   chk_ack_clear: assert property (@(posedge clk) // see R17
      disable iff (!rst_b) (cpu.irq_ack && !(|ev_set)) |=> !pending)
      else $error("ack did not clear pending");
   chk_mask_gate: assert property (@(posedge clk) // see R11
      cpu.irq_mask |-> !warn_irq)
      else $error("irq forwarded while masked");
   chk_halt_wake: assert property (@(posedge clk) // see R14
      cpu.halt_mode |-> !wake_req)
      else $error("wake from halt");

   //-------------------------------------------------------------------------
   // Further checks
   //-------------------------------------------------------------------------
   chk_pin_level: assert property (@(posedge clk) // see R04
      reset_pin_o == 1'b0)
      else $error("reset pin driven high");
   chk_pin_release: assert property (@(posedge clk) // see R04
      !low_reset |-> !reset_pin_oe)
      else $error("reset pin held without low supply");
   chk_illegal_reset: assert property (@(posedge clk) // see R15
      cpu.illegal_op |-> chip_reset)
      else $error("illegal opcode did not reset");
   chk_reset_source: assert property (@(posedge clk) // see R01
      chip_reset |-> (low_reset || cpu.illegal_op))
      else $error("reset without a cause");
   chk_sync_delay: assert property (@(posedge clk) // see R18
      (option.enable && $past(lv_meta)) |-> low_reset)
      else $error("low supply not passed through two stages");
   chk_lv_two_stage: assert property (@(posedge clk) // see R18
      $rose(lv_sync) |-> $past(lv_meta))
      else $error("low supply skipped first stage");
   chk_level_sel: assert property (@(posedge clk) // see R03
      cmp_level_sel == option.level)
      else $error("threshold select differs from option");
   chk_level_static: assert property (@(posedge clk) // see R09
      $stable(option.level) |-> $stable(cmp_level_sel))
      else $error("threshold moved without option change");
   chk_warn_gate: assert property (@(posedge clk) // see R08
      !option.enable |-> !warn_live)
      else $error("warning live while detector disabled");
   chk_off_status: assert property (@(posedge clk) // see R08
      disable iff (!rst_b)
      (!$past(option.enable) && !$past(cpu.halt_mode)) |-> !warn_status)
      else $error("warning status while detector disabled");
   chk_fall_status: assert property (@(posedge clk) // see R10
      disable iff (!rst_b) ev_set[SIM_EV_FALL] |=> ev_status[SIM_EV_FALL])
      else $error("falling crossing not recorded");
   chk_rise_status: assert property (@(posedge clk) // see R10
      disable iff (!rst_b) ev_set[SIM_EV_RISE] |=> ev_status[SIM_EV_RISE])
      else $error("rising crossing not recorded");
   chk_events_excl: assert property (@(posedge clk) // see R10
      !(ev_set[SIM_EV_FALL] && ev_set[SIM_EV_RISE]))
      else $error("both crossings at once");
   chk_fall_once: assert property (@(posedge clk) // see R10
      disable iff (!rst_b) ev_set[SIM_EV_FALL] |=> !ev_set[SIM_EV_FALL])
      else $error("falling crossing repeated");
   chk_rise_once: assert property (@(posedge clk) // see R10
      disable iff (!rst_b) ev_set[SIM_EV_RISE] |=> !ev_set[SIM_EV_RISE])
      else $error("rising crossing repeated");
   chk_fall_sticky: assert property (@(posedge clk) // see R10
      disable iff (!rst_b)
      (ev_status[0] && !(bus_wr && hit_st && avs_writedata[0]))
      |=> ev_status[0])
      else $error("falling status lost");
   chk_rise_sticky: assert property (@(posedge clk) // see R10
      disable iff (!rst_b)
      (ev_status[1] && !(bus_wr && hit_st && avs_writedata[1]))
      |=> ev_status[1])
      else $error("rising status lost");
   chk_fall_w1c: assert property (@(posedge clk) // see R10
      disable iff (!rst_b)
      (bus_wr && hit_st && avs_writedata[0] && !ev_set[0]) |=> !ev_status[0])
      else $error("falling status not cleared");
   chk_rise_w1c: assert property (@(posedge clk) // see R10
      disable iff (!rst_b)
      (bus_wr && hit_st && avs_writedata[1] && !ev_set[1]) |=> !ev_status[1])
      else $error("rising status not cleared");
   chk_irq_masked: assert property (@(posedge clk) // see R11
      (ev_mask == 2'h3) |-> !irq)
      else $error("irq while fully masked");
   chk_mask_reset: assert property (@(posedge clk) // see R11
      !rst_b |=> ev_mask == SIM_IRQ_MASK_RESET)
      else $error("mask reset value wrong");
   chk_status_reset: assert property (@(posedge clk) // see R10
      !rst_b |=> ev_status == 2'h0)
      else $error("event status not reset");
   chk_pend_reset: assert property (@(posedge clk) // see R17
      !rst_b |=> !pending)
      else $error("pending not reset");
   chk_en_reset: assert property (@(posedge clk) // see R11
      !rst_b |=> !irq_enable)
      else $error("irq enable not reset");
   chk_wstat_reset: assert property (@(posedge clk) // see R07
      !rst_b |=> !warn_status)
      else $error("warning status not reset");
   chk_halt_no_pend: assert property (@(posedge clk) // see R14
      disable iff (!rst_b) (cpu.halt_mode && !pending) |=> !pending)
      else $error("crossing pended in halt");
   chk_halt_csr: assert property (@(posedge clk) // see R13
      disable iff (!rst_b) cpu.halt_mode |=> $stable(irq_enable))
      else $error("irq enable changed in halt");
   chk_irq_fwd: assert property (@(posedge clk) // see R11
      (pending && !cpu.irq_mask) |-> warn_irq)
      else $error("unmasked request not forwarded");
   chk_irq_need_pend: assert property (@(posedge clk) // see R11
      warn_irq |-> pending)
      else $error("irq without pending request");
   chk_enable_gate: assert property (@(posedge clk) // see R11
      disable iff (!rst_b) (!irq_enable && !pending) |=> !pending)
      else $error("request pended while disabled");
   chk_wait_wake: assert property (@(posedge clk) // see R12
      (warn_irq && cpu.wait_mode && !cpu.halt_mode) |-> wake_req)
      else $error("no wake from wait");
   chk_wake_src: assert property (@(posedge clk) // see R12
      wake_req |-> (cpu.wait_mode && pending))
      else $error("wake without cause");
   chk_wait_same: assert property (@(posedge clk) // see R12
      disable iff (!rst_b)
      (cpu.wait_mode && !cpu.halt_mode) |=> warn_status == $past(warn_live))
      else $error("status stalled in wait");
   chk_cause_set: assert property (@(posedge clk) // see R16
      low_reset |=> reset_cause)
      else $error("reset cause not set");
   chk_cause_keep: assert property (@(posedge clk) // see R16
      (reset_cause &&
       !(bus_wr && hit_csr && !avs_writedata[SIM_BIT_RESET_CAUSE]))
      |=> reset_cause)
      else $error("reset cause lost");
   chk_cause_clear: assert property (@(posedge clk) // see R16
      (bus_wr && hit_csr && !avs_writedata[SIM_BIT_RESET_CAUSE] &&
       !low_reset) |=> !reset_cause)
      else $error("reset cause not cleared");
   chk_wdg_set: assert property (@(posedge clk) // see R06
      (cpu.wdg_reset && !low_reset) |=> wdg_cause)
      else $error("watchdog cause not set");
   chk_wdg_keep: assert property (@(posedge clk) // see R06
      (wdg_cause && !low_reset &&
       !(bus_wr && hit_csr && !avs_writedata[SIM_BIT_WDG_CAUSE]))
      |=> wdg_cause)
      else $error("watchdog cause lost");
   chk_read_csr: assert property (@(posedge clk) // see R07
      (bus_rd && hit_csr)
      |-> avs_readdata[SIM_BIT_WARN_STATUS] == warn_status)
      else $error("status bit not readable");
   chk_ro_status: assert property (@(posedge clk) // see R07
      disable iff (!rst_b)
      (bus_wr && hit_csr) |=> warn_status == $past(warn_live))
      else $error("write changed warning status");
   chk_read_idle: assert property (@(posedge clk) // see R07
      !bus_rd |-> avs_readdata == 32'h0)
      else $error("read data without read");
   chk_pend_hold: assert property (@(posedge clk) // see R17
      disable iff (!rst_b) (pending && !cpu.irq_ack) |=> pending)
      else $error("pending lost without ack");
   chk_lv_off: assert property (@(posedge clk) // see R05
      !option.enable |-> !reset_pin_oe)
      else $error("pin driven while detector disabled");
   chk_rise_pend: assert property (@(posedge clk) // see R10
      disable iff (!rst_b)
      (ev_set[SIM_EV_RISE] && irq_enable && !cpu.halt_mode) |=> pending)
      else $error("rising crossing did not pend");
   chk_enable_write: assert property (@(posedge clk) // see R11
      disable iff (!rst_b) (bus_wr && hit_csr)
      |=> irq_enable == $past(avs_writedata[SIM_BIT_IRQ_ENABLE]))
      else $error("irq enable write lost");
   chk_mask_write: assert property (@(posedge clk) // see R11
      disable iff (!rst_b) (bus_wr && hit_mk)
      |=> ev_mask == $past(avs_writedata[1:0]))
      else $error("mask write lost");

   cov_low_reset: cover property (@(posedge clk) low_reset ##1 !low_reset);
   cov_fall_irq: cover property (@(posedge clk)
      ev_set[SIM_EV_FALL] ##1 pending);
   cov_rise_irq: cover property (@(posedge clk)
      ev_set[SIM_EV_RISE] ##1 pending);
   cov_halt_event: cover property (@(posedge clk)
      cpu.halt_mode && |ev_set);
   cov_wake: cover property (@(posedge clk) wake_req);
endmodule // sim_monitor

/* File: verification/sim_supply_model.sv */
// Behavioural model of the analog supply comparators beside the monitor.
`timescale 1ns/100ps
module sim_supply_model
   import sim_pkg::*;
(
   input wire logic [7:0] supply,
   input wire logic [1:0] cmp_level_sel,
   output logic low_supply_cmp,
   output logic warn_cmp
);
   logic [7:0] lv_fall;
   logic [7:0] warn_fall;
   // The warning level rides on the reset level, so one option moves both.
   assign lv_fall = 8'h30 + {2'h0, cmp_level_sel, 4'h0};
   assign warn_fall = lv_fall + 8'h20;
   initial low_supply_cmp = 1'b0;
   initial warn_cmp = 1'b0;
   always @(supply or lv_fall) begin
      if (supply < lv_fall)
         low_supply_cmp = 1'b1;
      else if (supply >= lv_fall + 8'h04)
         low_supply_cmp = 1'b0;
      if (supply < warn_fall)
         warn_cmp = 1'b1;
      else if (supply >= warn_fall + 8'h08)
         warn_cmp = 1'b0;
   end
endmodule // sim_supply_model

/* File: verification/sim_monitor_tb_top.sv */
// Self-checking bench for the supply integrity monitor.
`timescale 1ns/100ps
module sim_monitor_tb_top;
   import sim_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] supply = 8'hc8;
   sim_option_s option = '{enable: 1'b1, level: SIM_LVL_MED};
   sim_cpu_s cpu = '0;
   logic low_supply_cmp, warn_cmp, chip_reset, reset_pin_o, reset_pin_oe;
   logic warn_irq, wake_req, irq, avs_waitrequest;
   logic [1:0] cmp_level_sel;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   int error_cnt = 0;
   int comparisons = 0;
   sim_supply_model sim_supply_model_i (.supply(supply),
      .cmp_level_sel(cmp_level_sel), .low_supply_cmp(low_supply_cmp),
      .warn_cmp(warn_cmp));
   sim_monitor sim_monitor_i (.clk(clk), .rst_b(rst_b),
      .low_supply_cmp(low_supply_cmp), .warn_cmp(warn_cmp), .option(option),
      .cpu(cpu), .cmp_level_sel(cmp_level_sel), .chip_reset(chip_reset),
      .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
      .warn_irq(warn_irq), .wake_req(wake_req), .irq(irq),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   initial begin
      forever #20 clk = ~clk;
   end
   //-------------------------------------------------------------------------
   // Access and comparison tasks
   //-------------------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One idle edge after each access keeps a strobe from being lowered and
   // raised again in the same time step.
   task automatic bus(input logic wr, input logic [3:0] a, input int d);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      cyc(2000);
      error_cnt++;
      summarize();
   end
   initial begin
      cyc(4);
      rst_b <= 1'b1;
      cyc(1);
      bus(0, SIM_ADDR_IRQ_MASK, 0); chk("mask", 32'h3, rd);
      bus(0, SIM_ADDR_CSR, 0); chk("csr", 32'h0, rd & 32'h3);
      for (int l = 0; l < 3; l++) begin
         option.level <= sim_level_e'(l);
         cyc(1);
         chk("level", l, {30'h0, cmp_level_sel});
      end
      option.level <= SIM_LVL_MED;
      $display("test reset done");
      bus(1, SIM_ADDR_CSR, 1);
      bus(1, SIM_ADDR_IRQ_MASK, 0);
      supply <= 8'h50;
      cyc(5);
      bus(1, SIM_ADDR_CSR, 1);
      bus(0, SIM_ADDR_CSR, 0); chk("warn", 32'h3, rd & 32'h3);
      chk("warn_irq", 1, warn_irq);
      chk("irq", 1, irq);
      cpu.wait_mode <= 1'b1;
      cyc(2); chk("wake", 1, wake_req);
      cpu.wait_mode <= 1'b0;
      cpu.irq_ack <= 1'b1;
      cyc(1);
      cpu.irq_ack <= 1'b0;
      cyc(1); chk("ack", 0, warn_irq);
      bus(1, SIM_ADDR_IRQ_STATUS, 3);
      bus(0, SIM_ADDR_IRQ_STATUS, 0); chk("w1c", 0, rd);
      supply <= 8'hc8;
      cyc(5); chk("rise irq", 1, warn_irq);
      bus(0, SIM_ADDR_IRQ_STATUS, 0); chk("rise ev", 32'h2, rd);
      cpu.irq_mask <= 1'b1;
      cyc(2); chk("masked", 0, warn_irq);
      $display("test warning done");
      cpu <= '{halt_mode: 1'b1, wait_mode: 1'b1, default: 1'b0};
      bus(1, SIM_ADDR_CSR, 0);
      supply <= 8'h50;
      cyc(5); chk("halt wake", 0, wake_req);
      chk("halt pend", 1, warn_irq);
      bus(0, SIM_ADDR_CSR, 0); chk("frozen", 1, rd[0]);
      chk("frozen warn", 0, rd[1]);
      cpu <= '{irq_ack: 1'b1, default: 1'b0};
      cyc(1);
      cpu.irq_ack <= 1'b0;
      supply <= 8'hc8;
      $display("test halt done");
      cpu.wdg_reset <= 1'b1;
      cyc(1);
      cpu.wdg_reset <= 1'b0;
      supply <= 8'h10;
      cyc(4);
      chk("lv rst", 5, {chip_reset, reset_pin_o, reset_pin_oe});
      bus(0, SIM_ADDR_CSR, 0); chk("cause", 2'h1, rd[3:2]);
      supply <= 8'hc8;
      cyc(4); chk("release", 0, chip_reset);
      bus(1, SIM_ADDR_CSR, 0);
      bus(0, SIM_ADDR_CSR, 0); chk("cause clr", 0, rd[2]);
      cpu.illegal_op <= 1'b1;
      cyc(2); chk("illegal", 1, chip_reset);
      cpu.illegal_op <= 1'b0;
      option.enable <= 1'b0;
      supply <= 8'h10;
      cyc(5); chk("off", 0, chip_reset);
      bus(0, SIM_ADDR_CSR, 0); chk("off warn", 0, rd[1]);
      $display("test low supply done");
      summarize();
   end
endmodule // sim_monitor_tb_top
